// file: design/ahp_device.sv
// converter end: control registers, sampling, sample fifo, flag
// Overview of operation
// - controller supplies free-running clock in continuous mode
// - trigger falling edge samples all enabled channels
// - first chip select counts only when low
// - second chip select counts only when high
// - flag output shows fifo fill level
// - flag polarity and level/pulse form programmable
// - ten-bit bidirectional bus, bit zero lsb
// - address lines steer writes to register 0/1
// - strobe is read/write line or write strobe
// - read strobe honoured only in write-only mode
// - first access after power-up is a write
// - register 0 selects external reference
// - internal oscillator paces single, off when continuous
// - sixteen-word result fifo read over bus
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module ahp_device
	import ahp_pkg::*;
(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rstn,
	// pins
	ahp_if.device                   pins,
	// held analog samples, channel n at bits n*10
	input  wire logic [NCH*DW-1:0]  analog_in,
	// status toward the analog side
	output logic                    ref_external,
	output logic                    continuous_mode,
	output logic                    osc_running,
	output logic [CNT_W-1:0]        fifo_count
);
	localparam int SW = DW + 7;

	typedef struct packed {
		logic [SW-1:0]                 sync1;
		logic [SW-1:0]                 sync2;
		logic [SW-1:0]                 prev;
		logic [DW-1:0]                 ctrl0;
		logic [DW-1:0]                 ctrl1;
		logic [FIFO_DEPTH-1:0][DW-1:0] mem;
		logic [PTR_W-1:0]              wptr;
		logic [PTR_W-1:0]              rptr;
		logic [CNT_W-1:0]              count;
		logic [NCH-1:0][DW-1:0]        snap;
		logic [NCH-1:0]                pend;
		logic [3:0]                    osc_cnt;
		logic                          above;
		logic [DW-1:0]                 d_out;
		logic                          d_oe;
		logic                          flag;
		logic                          wr_mode;
		logic                          osc_on;
	} ahp_dev_s;

	ahp_dev_s cur_ff;
	ahp_dev_s nxt_st;

	// both chip selects asserted: first low, second high
	function automatic logic sel_on(input logic [SW-1:0] v);
		sel_on = !v[DW] && v[DW+1];
	endfunction : sel_on

	// lowest pending channel number
	function automatic logic [1:0] first_ch(input logic [NCH-1:0] p);
		first_ch = 2'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (p[i]) begin
				first_ch = i[1:0];
			end
		end
	endfunction : first_ch

	// next-state logic for the whole port
	always_comb begin
		logic [SW-1:0] s;
		logic [SW-1:0] p;
		logic          sel;
		logic          wronly;
		logic          wr_ev;
		logic          rd_act;
		logic          pop;
		logic          push;
		logic          tick;
		logic          clr;
		logic [1:0]    ch;
		logic [3:0]    thr;
		logic          hit;
		s      = cur_ff.sync2;
		p      = cur_ff.prev;
		sel    = 1'b0;
		wronly = 1'b0;
		wr_ev  = 1'b0;
		rd_act = 1'b0;
		pop    = 1'b0;
		push   = 1'b0;
		tick   = 1'b0;
		clr    = 1'b0;
		ch     = 2'h0;
		thr    = 4'h0;
		hit    = 1'b0;
		nxt_st = cur_ff;
		// pins pass two flip-flops before use
		nxt_st.sync1 = {pins.sample_clock_in, pins.rd_n, pins.wr_strobe,
			pins.reg_addr_bit1, pins.reg_addr_bit0, pins.select_high,
			pins.select_low_n, pins.host_bus};
		nxt_st.sync2 = cur_ff.sync1;
		nxt_st.prev  = s;
		sel    = sel_on(s);
		wronly = cur_ff.wr_mode;
		// strobe mode follows the register only between accesses, so a
		// mode write never turns the open cycle into a read
		if (!sel) begin
			nxt_st.wr_mode = cur_ff.ctrl1[C1_WRONLY];
		end
		// write: rising write strobe, or end of select with rw low
		if (wronly) begin
			wr_ev = sel && s[DW+4] && !p[DW+4];
		end else begin
			wr_ev = sel_on(p) && !sel && !p[DW+4];
		end
		// read: read strobe low, or rw high while selected
		if (wronly) begin
			rd_act = sel && !s[DW+5];
			pop    = sel && s[DW+5] && !p[DW+5] && sel_on(p);
		end else begin
			rd_act = sel && s[DW+4];
			pop    = sel_on(p) && !sel && p[DW+4];
		end
		pop = pop && (cur_ff.count != '0);
		clr = 1'b0;
		// register write steered by the two address lines
		if (wr_ev) begin
			if (s[DW+3:DW+2] == RA_CTRL0) begin
				nxt_st.ctrl0 = s[DW-1:0];
			end else if (s[DW+3:DW+2] == RA_CTRL1) begin
				nxt_st.ctrl1 = s[DW-1:0];
				clr          = s[C1_FIFO_CLR];
			end
		end
		nxt_st.ctrl1[C1_FIFO_CLR] = 1'b0;
		// internal oscillator, stopped in continuous mode
		nxt_st.osc_on = !nxt_st.ctrl0[C0_CONT];
		if (cur_ff.ctrl0[C0_CONT]) begin
			nxt_st.osc_cnt = 4'h0;
			tick           = 1'b1;
		end else begin
			tick = (cur_ff.osc_cnt == 4'h0);
			if (tick) begin
				nxt_st.osc_cnt = 4'(OSC_CYCLES - 1);
			end else begin
				nxt_st.osc_cnt = cur_ff.osc_cnt - 4'h1;
			end
		end
		// falling edge on trigger/clock pin holds all channels at once
		if (!s[DW+6] && p[DW+6] && cur_ff.pend == '0) begin
			nxt_st.snap = analog_in;
			nxt_st.pend = cur_ff.ctrl0[C0_CHEN_LSB +: NCH];
		end
		// convert one pending channel per tick into the fifo
		ch   = first_ch(cur_ff.pend);
		push = tick && (cur_ff.pend != '0);
		if (push) begin
			nxt_st.pend[ch] = 1'b0;
		end
		push = push && (cur_ff.count != CNT_W'(FIFO_DEPTH));
		if (push) begin
			nxt_st.mem[cur_ff.wptr] = cur_ff.snap[ch];
			nxt_st.wptr             = cur_ff.wptr + 4'h1;
		end
		if (pop) begin
			nxt_st.rptr = cur_ff.rptr + 4'h1;
		end
		nxt_st.count = cur_ff.count + CNT_W'(push) - CNT_W'(pop);
		if (clr) begin
			nxt_st.wptr  = '0;
			nxt_st.rptr  = '0;
			nxt_st.count = '0;
		end
		// drive the fifo head only while selected and reading
		nxt_st.d_oe  = rd_act;
		nxt_st.d_out = (cur_ff.count != '0) ? cur_ff.mem[cur_ff.rptr]
			: 10'h000;
		// level flag: count above threshold, programmable form
		thr          = cur_ff.ctrl1[C1_THR_LSB +: 4];
		hit          = (cur_ff.count > {1'b0, thr});
		nxt_st.above = hit;
		if (cur_ff.ctrl1[C1_FLAG_PULSE]) begin
			hit = hit && !cur_ff.above;
		end
		// active-high form shows hit, active-low form its inverse
		nxt_st.flag = hit ~^ cur_ff.ctrl1[C1_FLAG_HIGH];
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cur_ff       <= '0;
			cur_ff.sync1 <= {SW{1'b1}};
			cur_ff.sync2 <= {SW{1'b1}};
			cur_ff.prev  <= {SW{1'b1}};
			cur_ff.ctrl0 <= CTRL0_RST;
			cur_ff.ctrl1 <= CTRL1_RST;
			cur_ff.flag  <= 1'b0;
			cur_ff.wr_mode <= CTRL1_RST[C1_WRONLY];
			cur_ff.osc_on  <= !CTRL0_RST[C0_CONT];
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign pins.dev_d_out       = cur_ff.d_out;
	assign pins.dev_d_oe        = cur_ff.d_oe;
	assign pins.fifo_level_flag = cur_ff.flag;
	assign ref_external         = cur_ff.ctrl0[C0_EXT_REF];
	assign continuous_mode      = cur_ff.ctrl0[C0_CONT];
	assign osc_running          = cur_ff.osc_on;
	assign fifo_count           = cur_ff.count;
endmodule : ahp_device

// file: design/ahp_pkg.sv
// constants shared by both ends of the converter host port
package ahp_pkg;
	// bus and sample geometry
	localparam int DW         = 10;
	localparam int NCH        = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W      = 4;
	localparam int CNT_W      = 5;

	// timing: core clock and derived cycle counts
	localparam int CORE_PERIOD_NS   = 4;
	localparam int OSC_PERIOD_NS    = 32;
	localparam int OSC_CYCLES       = OSC_PERIOD_NS / CORE_PERIOD_NS;
	localparam int PHASE_NS         = 32;
	localparam int PHASE_CYCLES     = PHASE_NS / CORE_PERIOD_NS;
	localparam int SCLK_HALF_NS     = 64;
	localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CORE_PERIOD_NS;

	// device register select codes on the two address lines
	localparam logic [1:0] RA_CTRL0 = 2'h0;
	localparam logic [1:0] RA_CTRL1 = 2'h1;

	// control register 0 fields
	localparam int C0_EXT_REF  = 0;
	localparam int C0_CONT     = 1;
	localparam int C0_CHEN_LSB = 2;
	// control register 1 fields
	localparam int C1_WRONLY     = 0;
	localparam int C1_FLAG_HIGH  = 1;
	localparam int C1_FLAG_PULSE = 2;
	localparam int C1_THR_LSB    = 3;
	localparam int C1_FIFO_CLR   = 9;

	// device control values after reset
	localparam logic [9:0] CTRL0_RST = 10'h03c;
	localparam logic [9:0] CTRL1_RST = 10'h003;

	// host register byte offsets on the avalon slave
	localparam logic [3:0] AV_WRITE_OFS = 4'h0;
	localparam logic [3:0] AV_READ_OFS  = 4'h4;
	localparam logic [3:0] AV_CFG_OFS   = 4'h8;
	localparam logic [3:0] AV_STAT_OFS  = 4'hc;
	// host register fields
	localparam int CMD_RA_LSB   = 10;
	localparam int CFG_WRONLY   = 0;
	localparam int CFG_CONT     = 1;
	localparam int CFG_TRIG     = 2;
	localparam int ST_BUSY      = 0;
	localparam int ST_FLAG      = 1;
	localparam int ST_INIT      = 2;
	localparam int ST_VALID     = 3;
	localparam logic [1:0] HOST_CFG_RST = 2'h1;
endpackage : ahp_pkg

// file: design/ahp_if.sv
// pin-level carrier between the converter port and its bus controller
`timescale 1ns/1ps
interface ahp_if;
	// shared data bus pieces
	logic [9:0] host_d_out;
	logic       host_d_oe;
	logic [9:0] dev_d_out;
	logic       dev_d_oe;
	// controller driven pins
	logic       select_low_n;
	logic       select_high;
	logic       reg_addr_bit0;
	logic       reg_addr_bit1;
	logic       wr_strobe;
	logic       rd_n;
	logic       sample_clock_in;
	// device driven flag
	logic       fifo_level_flag;
	// resolved bus level, undriven bus floats high
	wire  [9:0] host_bus;

	assign host_bus = dev_d_oe ? dev_d_out :
		(host_d_oe ? host_d_out : 10'h3ff);

	modport device (
		input  host_bus, select_low_n, select_high, reg_addr_bit0,
		input  reg_addr_bit1, wr_strobe, rd_n, sample_clock_in,
		output dev_d_out, dev_d_oe, fifo_level_flag
	);
	modport host (
		input  host_bus, fifo_level_flag,
		output host_d_out, host_d_oe, select_low_n, select_high,
		output reg_addr_bit0, reg_addr_bit1, wr_strobe, rd_n,
		output sample_clock_in
	);
endinterface : ahp_if

// file: design/ahp_host.sv
// controller end: avalon-mm slave that runs pin cycles to the converter
`timescale 1ns/1ps
module ahp_host
	import ahp_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// pins
	ahp_if.host              pins
);
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_REL} ahp_st_e;

	typedef struct packed {
		ahp_st_e     state;
		logic [3:0]  ph;
		logic        is_rd;
		logic [9:0]  wdata;
		logic [1:0]  ra;
		logic [9:0]  rdata;
		logic        valid;
		logic        init;
		logic [1:0]  cfg;
		logic        sclk;
		logic [4:0]  sclk_cnt;
		logic [9:0]  sync1;
		logic [9:0]  sync2;
		logic        flag1;
		logic        flag2;
		logic        wait_r;
		logic [31:0] rdat;
		logic [9:0]  d_out;
		logic        d_oe;
		logic        cs_n;
		logic        cs_h;
		logic        wr;
		logic        rd_n;
	} ahp_host_s;

	ahp_host_s cur_ff;
	ahp_host_s nxt_st;

	// next-state logic
	always_comb begin
		logic req;
		logic busy;
		logic ok;
		logic done;
		logic ack;
		req          = 1'b0;
		busy         = 1'b0;
		ok           = 1'b0;
		done         = 1'b0;
		ack          = 1'b0;
		nxt_st       = cur_ff;
		nxt_st.sync1 = pins.host_bus;
		nxt_st.sync2 = cur_ff.sync1;
		nxt_st.flag1 = pins.fifo_level_flag;
		nxt_st.flag2 = cur_ff.flag1;
		busy         = cur_ff.state != ST_IDLE;
		req          = avs_read || avs_write;
		ok = !((avs_address == AV_WRITE_OFS || avs_address == AV_READ_OFS)
			&& avs_write && busy);
		nxt_st.wait_r = 1'b1;
		ack           = req && cur_ff.wait_r && ok;
		// a write lands only at the edge that samples waitrequest low
		done          = avs_write && !cur_ff.wait_r;
		// pin sequencer phases
		if (busy) begin
			if (cur_ff.ph == 4'h0) begin
				nxt_st.ph = 4'(PHASE_CYCLES - 1);
				case (cur_ff.state)
					ST_SETUP:  nxt_st.state = ST_STROBE;
					ST_STROBE: begin
						nxt_st.state = ST_HOLD;
						if (cur_ff.is_rd) begin
							nxt_st.rdata = cur_ff.sync2;
							nxt_st.valid = 1'b1;
						end
					end
					ST_HOLD:   nxt_st.state = ST_REL;
					ST_REL:    nxt_st.state = ST_IDLE;
					default:   nxt_st.state = ST_IDLE;
				endcase
			end else begin
				nxt_st.ph = cur_ff.ph - 4'h1;
			end
		end
		// answer an avalon access one cycle after it is seen; a write to the write or read offset waits until the pins are idle
		if (ack) begin
			nxt_st.wait_r = 1'b0;
			nxt_st.rdat   = 32'h0;
			if (avs_read) begin
				case (avs_address)
					AV_READ_OFS: nxt_st.rdat[9:0] = cur_ff.rdata;
					AV_CFG_OFS:  nxt_st.rdat[1:0] = cur_ff.cfg;
					AV_STAT_OFS: nxt_st.rdat[3:0] = {cur_ff.valid,
						cur_ff.init, cur_ff.flag2, busy};
					default:     nxt_st.rdat = 32'h0;
				endcase
			end
		end
		// commit a write at the edge that takes its answer
		if (done) begin
				case (avs_address)
					AV_WRITE_OFS: begin
						nxt_st.state = ST_SETUP;
						nxt_st.ph    = 4'(PHASE_CYCLES - 1);
						nxt_st.is_rd = 1'b0;
						nxt_st.wdata = avs_writedata[9:0];
						nxt_st.ra    = avs_writedata[CMD_RA_LSB +: 2];
						nxt_st.init  = 1'b1;
					end
					AV_READ_OFS: begin
						// refused until a write to the write offset has gone out to the device
						if (cur_ff.init) begin
							nxt_st.state = ST_SETUP;
							nxt_st.ph    = 4'(PHASE_CYCLES - 1);
							nxt_st.is_rd = 1'b1;
							nxt_st.valid = 1'b0;
						end
					end
					AV_CFG_OFS: begin
						nxt_st.cfg = avs_writedata[1:0];
						if (avs_writedata[CFG_TRIG]) begin
							nxt_st.sclk     = 1'b0;
							nxt_st.sclk_cnt = 5'(SCLK_HALF_CYCLES - 1);
						end
					end
					default: nxt_st.cfg = cur_ff.cfg;
				endcase
		end
		// conversion pin: free clock, or a low pulse then idle high
		if (cur_ff.sclk_cnt != 5'h0) begin
			nxt_st.sclk_cnt = cur_ff.sclk_cnt - 5'h1;
		end else if (cur_ff.cfg[CFG_CONT]) begin
			nxt_st.sclk     = !cur_ff.sclk;
			nxt_st.sclk_cnt = 5'(SCLK_HALF_CYCLES - 1);
		end else if (!(done && avs_write && avs_address == AV_CFG_OFS
			&& avs_writedata[CFG_TRIG])) begin
			nxt_st.sclk = 1'b1;
		end
		// pin levels for the coming state
		nxt_st.cs_n = !(nxt_st.state != ST_IDLE && nxt_st.state != ST_REL);
		nxt_st.cs_h = !nxt_st.cs_n;
		nxt_st.d_oe = nxt_st.state != ST_IDLE && !nxt_st.is_rd;
		nxt_st.d_out = nxt_st.wdata;
		if (cur_ff.cfg[CFG_WRONLY]) begin
			nxt_st.wr   = !(nxt_st.state == ST_STROBE && !nxt_st.is_rd);
			nxt_st.rd_n = !(nxt_st.state == ST_STROBE && nxt_st.is_rd);
		end else begin
			nxt_st.wr   = nxt_st.is_rd;
			nxt_st.rd_n = 1'b1;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cur_ff        <= '0;
			cur_ff.state  <= ST_IDLE;
			cur_ff.cfg    <= HOST_CFG_RST;
			cur_ff.sclk   <= 1'b1;
			cur_ff.wait_r <= 1'b1;
			cur_ff.cs_n   <= 1'b1;
			cur_ff.wr     <= 1'b1;
			cur_ff.rd_n   <= 1'b1;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign avs_readdata         = cur_ff.rdat;
	assign avs_waitrequest      = cur_ff.wait_r;
	assign pins.host_d_out      = cur_ff.d_out;
	assign pins.host_d_oe       = cur_ff.d_oe;
	assign pins.select_low_n    = cur_ff.cs_n;
	assign pins.select_high     = cur_ff.cs_h;
	assign pins.reg_addr_bit0   = cur_ff.ra[0];
	assign pins.reg_addr_bit1   = cur_ff.ra[1];
	assign pins.wr_strobe       = cur_ff.wr;
	assign pins.rd_n            = cur_ff.rd_n;
	assign pins.sample_clock_in = cur_ff.sclk;
endmodule : ahp_host

// file: testbench/ahp_props.sv
// pin-level checks on the wires joining the two ends
`timescale 1ns/1ps
module ahp_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// pins
	input wire logic host_d_oe,
	input wire logic dev_d_oe,
	input wire logic select_low_n,
	input wire logic select_high,
	input wire logic wr_strobe,
	input wire logic rd_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// device counts as chosen only with both selects asserted
	wire sel_both = !select_low_n && select_high;

	// step sequences of read and write cycles
	sequence s_desel; !sel_both [*4]; endsequence
	sequence s_rd_start; $fell(rd_n) ##0 sel_both; endsequence
	// strobe rising inside an access that was already open
	sequence s_wr_end;
		$rose(wr_strobe) ##0 sel_both ##0 $past(sel_both);
	endsequence

	// bus ownership
	a_bus_released: assert property (s_desel |-> !dev_d_oe)
		else $error("bus driven while deselected");
	a_no_contention: assert property (!(dev_d_oe && host_d_oe))
		else $error("both ends drive the bus");
	a_drive_cause: assert property ($rose(dev_d_oe) |->
		$past(sel_both, 2) && (!$past(rd_n, 2) || $past(wr_strobe, 2)))
		else $error("device drove bus without a read request");
	// read strobe shape
	a_rd_setup: assert property (s_rd_start |-> $past(sel_both, 8))
		else $error("read strobe without select setup");
	a_rd_width: assert property (s_rd_start |-> !rd_n [*8])
		else $error("read strobe not eight cycles");
	a_rd_release: assert property ($rose(rd_n) && sel_both |->
		##[1:6] !dev_d_oe)
		else $error("bus not released after read");
	// write data and select pairing
	a_wr_data: assert property (s_wr_end |-> host_d_oe)
		else $error("write strobe ended without data");
	a_sel_pair: assert property ($changed(select_low_n) |->
		$changed(select_high))
		else $error("selects moved apart");
endmodule : ahp_props

// file: testbench/adc_parallel_host_port_tb.sv
// self-checking bench joining both ends of the converter host port
`timescale 1ns/1ps
module adc_parallel_host_port_tb
	import ahp_pkg::*;
;
	logic              core_clk = 1'b0;
	logic              rstn = 1'b0;
	logic [3:0]        avs_address = 4'h0;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = 32'h0;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic [NCH*DW-1:0] analog_in = {10'h2a5, 10'h15a, 10'h3c3, 10'h0f1};
	logic              ref_external;
	logic              continuous_mode;
	logic              osc_running;
	logic [CNT_W-1:0]  fifo_count;
	logic [31:0]       q;
	int                n_mismatch = 0;
	int                checks = 0;
	int                n_hi = 0;
	// rows: register code, data, expected ref and continuous
	logic [13:0]       rows [5] = '{14'h00f6, 14'h20fa, 14'h00f0,
		14'h30fc, 14'h100c};

	ahp_if u_ahp_if ();
	ahp_device u_ahp_device (.core_clk, .rstn, .pins(u_ahp_if.device),
		.analog_in, .ref_external, .continuous_mode, .osc_running,
		.fifo_count);
	ahp_host u_ahp_host (.core_clk, .rstn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.pins(u_ahp_if.host));
	ahp_props u_ahp_props (.core_clk, .rstn,
		.host_d_oe(u_ahp_if.host_d_oe), .dev_d_oe(u_ahp_if.dev_d_oe),
		.select_low_n(u_ahp_if.select_low_n),
		.select_high(u_ahp_if.select_high),
		.wr_strobe(u_ahp_if.wr_strobe), .rd_n(u_ahp_if.rd_n));

	// clock and flag high-cycle counter
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) if (u_ahp_if.fifo_level_flag === 1'b1) n_hi++;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one avalon transfer, held until waitrequest is seen low
	task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av

	task automatic idle;
		do av(AV_STAT_OFS, 1'b0, 32'h0); while (q[ST_BUSY] !== 1'b0);
	endtask : idle

	task automatic dw(input logic [1:0] ra, input logic [9:0] d);
		av(AV_WRITE_OFS, 1'b1, {20'h0, ra, d});
		idle();
	endtask : dw

	task automatic rd_word;
		av(AV_READ_OFS, 1'b1, 32'h0);
		idle();
		av(AV_READ_OFS, 1'b0, 32'h0);
	endtask : rd_word

	task automatic waitcnt(input logic [4:0] e);
		for (int i = 0; i < 400 && fifo_count !== e; i++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
		chk(fifo_count, e);
	endtask : waitcnt

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// watchdog
	initial begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		av(AV_CFG_OFS, 1'b0, 32'h0);
		chk(q, {30'h0, HOST_CFG_RST});
		chk({ref_external, continuous_mode, osc_running, fifo_count},
			8'h20);
		av(AV_READ_OFS, 1'b1, 32'h0);
		av(AV_STAT_OFS, 1'b0, 32'h0);
		chk(q[ST_VALID], 1'b0);
		for (int r = 0; r < 5; r++) begin
			dw(rows[r][13:12], rows[r][11:2]);
			chk({ref_external, continuous_mode}, rows[r][1:0]);
		end
		$display("test registers done");
		av(AV_CFG_OFS, 1'b1, 32'h5);
		waitcnt(5'd4);
		chk(u_ahp_if.fifo_level_flag, 1'b1);
		av(AV_STAT_OFS, 1'b0, 32'h0);
		chk(q[ST_FLAG], 1'b1);
		for (int c = 0; c < NCH; c++) begin
			rd_word();
			chk(q[9:0], analog_in[c*DW +: DW]);
		end
		waitcnt(5'd0);
		chk(u_ahp_if.fifo_level_flag, 1'b0);
		$display("test single done");
		dw(RA_CTRL1, 10'h001);
		chk(u_ahp_if.fifo_level_flag, 1'b1);
		dw(RA_CTRL1, 10'h007);
		n_hi = 0;
		av(AV_CFG_OFS, 1'b1, 32'h5);
		waitcnt(5'd4);
		chk(n_hi, 1);
		dw(RA_CTRL1, 10'h203);
		waitcnt(5'd0);
		$display("test flag done");
		for (int k = 0; k < 5; k++) begin
			av(AV_CFG_OFS, 1'b1, 32'h5);
			repeat (80) @(posedge core_clk);
		end
		chk(fifo_count, 5'd16);
		dw(RA_CTRL1, 10'h203);
		dw(RA_CTRL0, 10'h03e);
		av(AV_CFG_OFS, 1'b1, 32'h3);
		waitcnt(5'd16);
		chk({continuous_mode, osc_running}, 2'b10);
		av(AV_CFG_OFS, 1'b1, 32'h1);
		dw(RA_CTRL0, 10'h03c);
		dw(RA_CTRL1, 10'h203);
		$display("test fill done");
		dw(RA_CTRL1, 10'h002);
		av(AV_CFG_OFS, 1'b1, 32'h4);
		waitcnt(5'd4);
		rd_word();
		chk(q[9:0], 10'h0f1);
		chk(fifo_count, 5'd3);
		dw(RA_CTRL1, 10'h203);
		waitcnt(5'd0);
		av(AV_CFG_OFS, 1'b1, 32'h1);
		$display("test rw done");
		dw(RA_CTRL0, 10'h03d);
		av(AV_CFG_OFS, 1'b1, 32'h5);
		repeat (30) @(posedge core_clk);
		rstn <= 1'b0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		chk({ref_external, continuous_mode, osc_running, fifo_count,
			u_ahp_if.fifo_level_flag}, 9'h040);
		av(AV_STAT_OFS, 1'b0, 32'h0);
		chk(q[ST_INIT], 1'b0);
		$display("test reset done");
		conclude();
	end
endmodule : adc_parallel_host_port_tb
